// [scpc_divider.sv]
// glitch-free power-of-two clock divider with edge-aligned setting change
`timescale 1ns/10ps
`default_nettype none
module scpc_divider #(
    parameter int SEL_W = 4
) (
    input wire logic clk_sys, // undivided source clock
    input wire logic rst, // async reset, active high
    input wire logic [SEL_W-1:0] sel_in, // requested division exponent
    output logic clk_en, // one-cycle active edge of divided clock
    output logic [SEL_W-1:0] sel_active // exponent now in force
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] mask_w;
    logic [SEL_W-1:0] sel_r;
    logic edge_w;

    // count state stays internal, no software view
    assign mask_w = 8'(({8'h0, 1'b1} << sel_r) - 9'h001);
    assign edge_w = (cnt_r & mask_w) == mask_w;
    assign cnt_nxt = edge_w ? 8'h00 : 8'(cnt_r + 8'h01);
    assign clk_en = edge_w;
    assign sel_active = sel_r;

    // new ratio latched only at an active edge: no runt, no faster period
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= 8'h00;
            sel_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
            if (edge_w) begin
                sel_r <= sel_in;
            end
        end
    end

    // sel_in taken into sel_r on the cycle after an active edge that sees it differ
    sel_switch_a: assert property (@(posedge clk_sys) disable iff (rst)
        edge_w && sel_r != sel_in |=> sel_r == $past(sel_in))
        else $error("ratio not taken at edge");
endmodule
`default_nettype wire

// [scpc_pkg.sv]
// package: register map, fields, reset values and timing for the clock prescaler control
package scpc_pkg;
    localparam int SCPC_ADDR_W = 4;
    localparam logic [3:0] SCPC_OFF_TRIM = 4'h0;
    localparam logic [3:0] SCPC_OFF_PLL = 4'h4;
    localparam logic [3:0] SCPC_OFF_DIV = 4'h8;
    localparam int SCPC_UNLOCK_BIT = 7;
    localparam int SCPC_SEL_MSB = 3;
    localparam int SCPC_TRIM_RANGE_BIT = 7;
    localparam int SCPC_PLL_RATE_BIT = 2;
    localparam int SCPC_PLL_ON_BIT = 1;
    localparam int SCPC_PLL_LOCK_BIT = 0;
    localparam logic [3:0] SCPC_SEL_RST_PLAIN = 4'h0;
    localparam logic [3:0] SCPC_SEL_RST_DIV8 = 4'h3;
    localparam logic [3:0] SCPC_SEL_MAX = 4'h8;
    localparam logic [2:0] SCPC_UNLOCK_CYCLES = 3'h4;
    localparam int SCPC_CLK_HZ = 10000000;
    localparam int SCPC_LOCK_TIME_MS = 100;
    localparam int SCPC_LOCK_CYCLES = (SCPC_CLK_HZ / 1000) * SCPC_LOCK_TIME_MS;
    localparam int SCPC_PLL_REF_MHZ = 1;
    localparam int SCPC_PLL_MULT = 64;
    localparam int SCPC_PLL_HI_MHZ = 64;
    localparam int SCPC_PLL_LO_MHZ = 32;
    typedef enum logic [2:0] {
        SCPC_PLL_OFF = 3'b001,
        SCPC_PLL_WAIT = 3'b010,
        SCPC_PLL_LOCK = 3'b100
    } scpc_pll_st_t;
endpackage

// [scpc_top.sv]
// clock prescaler, oscillator trim and pll control with avalon-mm slave
`timescale 1ns/10ps
`default_nettype none
module scpc_top
    import scpc_pkg::*;
#(
    parameter int LOCK_CYCLES = scpc_pkg::SCPC_LOCK_CYCLES,
    parameter logic [7:0] FACTORY_TRIM = 8'h80 // arbitrary neutral calibration value
) (
    input wire logic clk_sys, // undivided source clock
    input wire logic rst, // async reset, active high
    input wire logic div_by_eight_fuse, // fuse programmed when high
    input wire logic pll_is_sys_clock, // pll selected as system clock source
    input wire logic [scpc_pkg::SCPC_ADDR_W-1:0] avs_address, // byte address
    input wire logic avs_read, // read request
    input wire logic avs_write, // write request
    input wire logic [31:0] avs_writedata, // write data
    input wire logic [3:0] avs_byteenable, // byte enables
    output logic [31:0] avs_readdata, // read data
    output logic avs_waitrequest, // stall
    output logic io_clock, // io domain clock enable
    output logic converter_clock, // converter domain clock enable
    output logic cpu_clock, // cpu domain clock enable
    output logic flash_clock, // flash domain clock enable
    output logic [7:0] osc_trim_out, // trim to rc oscillator
    output logic trim_range_select, // oscillator range
    output logic [6:0] trim_fine_value, // oscillator fine tune
    output logic pll_run, // pll started
    output logic osc_run, // rc oscillator requested as reference
    output logic pll_rate_select, // 1: 64 MHz, 0: 32 MHz
    output logic [6:0] pll_ref_div, // multiplier times reference mhz exported
    output logic pll_locked_flag // pll lock status
);
    import scpc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus decode
    logic acc_r;
    logic rd_hit_trim;
    logic wr_w;
    logic wr_trim;
    logic wr_pll;
    logic wr_div;
    logic lane0;
    logic [7:0] wbyte;
    logic [7:0] rd_byte;
    logic [31:0] rdata_r;

    // one wait cycle per access; request taken on the second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~acc_r;
    assign lane0 = avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign wr_w = avs_write & acc_r & lane0;
    assign wr_trim = wr_w && avs_address == SCPC_OFF_TRIM;
    assign wr_pll = wr_w && avs_address == SCPC_OFF_PLL;
    assign wr_div = wr_w && avs_address == SCPC_OFF_DIV;
    assign rd_hit_trim = avs_address == SCPC_OFF_TRIM;
    assign avs_readdata = rdata_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_r <= 1'b0;
        end else begin
            acc_r <= (avs_read | avs_write) & ~acc_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler register and unlock window
    logic unlock_r;
    logic [2:0] win_r;
    logic [3:0] sel_r;
    logic sel_loaded_r;
    logic unlock_req;
    logic sel_req;
    logic [3:0] sel_active;
    logic div_edge;

    assign unlock_req = wr_div && wbyte == 8'h80;
    assign sel_req = wr_div && !wbyte[SCPC_UNLOCK_BIT] && unlock_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            unlock_r <= 1'b0;
            win_r <= 3'h0;
        end else if (sel_req) begin
            unlock_r <= 1'b0;
            win_r <= 3'h0;
        end else if (unlock_r) begin
            // window not restarted by a repeated unlock
            win_r <= 3'(win_r + 3'h1);
            if (win_r == SCPC_UNLOCK_CYCLES - 3'h1) begin
                unlock_r <= 1'b0;
            end
        end else if (unlock_req) begin
            unlock_r <= 1'b1;
            win_r <= 3'h0;
        end
    end

    // fuse caught by a clocked load at the first edge after release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sel_r <= SCPC_SEL_RST_PLAIN;
            sel_loaded_r <= 1'b0;
        end else if (!sel_loaded_r) begin
            sel_loaded_r <= 1'b1;
            sel_r <= div_by_eight_fuse ? SCPC_SEL_RST_DIV8 : SCPC_SEL_RST_PLAIN;
        end else if (sel_req) begin
            sel_r <= wbyte[SCPC_SEL_MSB:0];
        end
    end

    logic [3:0] sel_eff;
    // reserved codes clamp to the slowest legal ratio
    assign sel_eff = sel_r > SCPC_SEL_MAX ? SCPC_SEL_MAX : sel_r;

    scpc_divider #(
        .SEL_W(4)
    ) u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .sel_in(sel_eff),
        .clk_en(div_edge),
        .sel_active(sel_active)
    );

    // same divided edge to every synchronous domain
    assign io_clock = div_edge;
    assign converter_clock = div_edge;
    assign cpu_clock = div_edge;
    assign flash_clock = div_edge;

    ////////////////////////////////////////////////////////////////////////
    // oscillator trim
    logic [7:0] trim_r;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trim_r <= FACTORY_TRIM;
        end else if (wr_trim) begin
            trim_r <= wbyte;
        end
    end

    assign osc_trim_out = trim_r;
    assign trim_range_select = trim_r[SCPC_TRIM_RANGE_BIT];
    assign trim_fine_value = trim_r[6:0];

    ////////////////////////////////////////////////////////////////////////
    // pll control and lock timer
    logic pll_on_r;
    logic rate_r;
    logic pll_on_rd;
    logic [31:0] lock_cnt_r;
    scpc_pll_st_t pst_r;
    scpc_pll_st_t pst_nxt;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pll_on_r <= 1'b0;
            rate_r <= 1'b0;
        end else if (wr_pll) begin
            pll_on_r <= wbyte[SCPC_PLL_ON_BIT];
            rate_r <= wbyte[SCPC_PLL_RATE_BIT];
        end
    end

    assign pll_on_rd = pll_on_r | pll_is_sys_clock;

    always_comb begin
        pst_nxt = pst_r;
        case (pst_r)
            SCPC_PLL_OFF: begin
                if (pll_on_rd) begin
                    pst_nxt = SCPC_PLL_WAIT;
                end
            end
            SCPC_PLL_WAIT: begin
                if (!pll_on_rd) begin
                    pst_nxt = SCPC_PLL_OFF;
                end else if (lock_cnt_r == 32'(LOCK_CYCLES - 1)) begin
                    pst_nxt = SCPC_PLL_LOCK;
                end
            end
            SCPC_PLL_LOCK: begin
                if (!pll_on_rd) begin
                    pst_nxt = SCPC_PLL_OFF;
                end
            end
            default: begin
                pst_nxt = SCPC_PLL_OFF;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pst_r <= SCPC_PLL_OFF;
            lock_cnt_r <= 32'h0;
        end else begin
            pst_r <= pst_nxt;
            lock_cnt_r <= pst_r == SCPC_PLL_WAIT ? 32'(lock_cnt_r + 32'h1) : 32'h0;
        end
    end

    assign pll_run = pll_on_rd;
    assign osc_run = pll_on_rd;
    assign pll_rate_select = rate_r;
    assign pll_locked_flag = pst_r == SCPC_PLL_LOCK;
    assign pll_ref_div = 7'(SCPC_PLL_MULT * SCPC_PLL_REF_MHZ);

    ////////////////////////////////////////////////////////////////////////
    // read mux
    always_comb begin
        rd_byte = 8'h00;
        if (rd_hit_trim) begin
            rd_byte = trim_r;
        end else if (avs_address == SCPC_OFF_PLL) begin
            rd_byte = {5'h00, rate_r, pll_on_rd, pll_locked_flag};
        end else if (avs_address == SCPC_OFF_DIV) begin
            rd_byte = {unlock_r, 3'h0, sel_r};
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0;
        end else if (avs_read & ~acc_r) begin
            rdata_r <= {24'h000000, rd_byte};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence unlock_open_s;
        !unlock_r ##1 unlock_r;
    endsequence

    unlock_only_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(unlock_r) |-> $past(wr_div) && $past(wbyte) == 8'h80)
        else $error("bad unlock");
    // window is four sampled cycles high from the first one seen set
    unlock_timeout_a: assert property (@(posedge clk_sys) disable iff (rst)
        unlock_open_s |-> ##[1:4] !unlock_r)
        else $error("unlock window too long");
    unlock_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
        unlock_open_s ##0 !sel_req [*3] |-> unlock_r)
        else $error("unlock dropped early");
    // fuse load edge excluded: loaded flag and field change together
    sel_guard_a: assert property (@(posedge clk_sys) disable iff (rst)
        $past(sel_loaded_r) && $changed(sel_r) |-> $past(unlock_r) && $past(wr_div))
        else $error("unguarded ratio");
    sel_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
        sel_req |=> !unlock_r)
        else $error("unlock not cleared by write");
    fuse_load_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(sel_loaded_r) |->
            sel_r == ($past(div_by_eight_fuse) ? SCPC_SEL_RST_DIV8 : SCPC_SEL_RST_PLAIN))
        else $error("reset ratio");
    pll_rsvd_a: assert property (@(posedge clk_sys) disable iff (rst)
        acc_r && avs_read && avs_address == SCPC_OFF_PLL |-> rdata_r[7:3] == 5'h00)
        else $error("reserved set");
    // counter has taken one more step on the edge that sets the lock state
    lock_late_a: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(pll_locked_flag) |->
            lock_cnt_r == 32'(LOCK_CYCLES) && $past(lock_cnt_r) == 32'(LOCK_CYCLES - 1))
        else $error("lock timing");
    pll_sys_a: assert property (@(posedge clk_sys) disable iff (rst)
        pll_is_sys_clock |-> pll_run)
        else $error("pll off while system clock");
    sel_clamp_a: assert property (@(posedge clk_sys) disable iff (rst)
        sel_active <= SCPC_SEL_MAX)
        else $error("reserved ratio used");
endmodule
`default_nettype wire

// [tb_scpc_top.sv]
// self-checking testbench for the clock prescaler control block
`timescale 1ns/10ps
`default_nettype none
module tb_scpc_top;
    import scpc_pkg::*;
    localparam int LOCK_SIM = 20;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic fuse = 1'b1;
    logic pll_sys = 1'b0;
    logic [SCPC_ADDR_W-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'hF;
    logic [31:0] rdata;
    logic wait_req;
    logic io_clk;
    logic cnv_clk;
    logic cpu_clk;
    logic fl_clk;
    logic [7:0] trim_out;
    logic range_sel;
    logic [6:0] fine;
    logic pll_run;
    logic osc_run;
    logic rate_sel;
    logic [6:0] ref_div;
    logic locked;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 18;
    int cycles = 0;
    logic [7:0] v;
    logic [3:0] cur;

    scpc_top #(.LOCK_CYCLES(LOCK_SIM)) DUT (.clk_sys(clk_sys), .rst(rst),
        .div_by_eight_fuse(fuse), .pll_is_sys_clock(pll_sys), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(be),
        .avs_readdata(rdata), .avs_waitrequest(wait_req), .io_clock(io_clk),
        .converter_clock(cnv_clk), .cpu_clock(cpu_clk), .flash_clock(fl_clk),
        .osc_trim_out(trim_out), .trim_range_select(range_sel), .trim_fine_value(fine),
        .pll_run(pll_run), .osc_run(osc_run), .pll_rate_select(rate_sel),
        .pll_ref_div(ref_div), .pll_locked_flag(locked));

    always #50 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: period %h expected %h", $time, got, exp);
        end
    endtask

    function automatic int per(input logic [3:0] c);
        return 1 << ((c > SCPC_SEL_MAX) ? 8 : c);
    endfunction

    // all four domain enables must pulse together
    always @(posedge clk_sys) begin
        if (!rst) begin
            chk_reg({28'h0, io_clk, cnv_clk, cpu_clk, fl_clk}, {28'h0, {4{io_clk === 1'b1}}});
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request stays up on return so calls can run back to back
    task automatic bus(input logic is_rd, input logic [3:0] a, input logic [7:0] d,
            output logic [31:0] q);
        addr <= a;
        rd <= is_rd;
        wr <= !is_rd;
        wdata <= {24'($random(seed)), d};
        // only the bench timeout ends a hung wait
        do begin
            @(posedge clk_sys);
        end while (wait_req !== 1'b0);
        q = rdata;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 8'h00, q);
        chk_reg(q, exp);
    endtask

    task automatic idle(input int n);
        rd <= 1'b0;
        wr <= 1'b0;
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic next_pulse(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (io_clk !== 1'b1 && n < 600);
    endtask

    task automatic measure(input logic [3:0] c);
        int n;
        next_pulse(n);
        next_pulse(n);
        chk_cnt(n, per(c));
        next_pulse(n);
        chk_cnt(n, per(c));
    endtask

    task automatic set_div(input logic [3:0] c);
        wr_reg(SCPC_OFF_DIV, 8'h80);
        wr_reg(SCPC_OFF_DIV, {4'h0, c});
        rd_chk(SCPC_OFF_DIV, {28'h0, c});
        idle(1);
        measure(c);
        cur = c;
    endtask

    task automatic reset_dut(input logic f);
        rst <= 1'b1;
        fuse <= f;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_dut(1'b1);
        rd_chk(SCPC_OFF_TRIM, 32'h80);
        rd_chk(SCPC_OFF_PLL, 32'h0);
        rd_chk(SCPC_OFF_DIV, 32'h3);
        rd_chk(4'hC, 32'h0);
        wr_reg(4'hC, 8'hFF);
        rd_chk(4'hC, 32'h0);
        idle(1);
        measure(4'h3);
        chk_reg({25'h0, ref_div}, 32'h40);
        cur = 4'h3;
        $display("test reset values done");
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'h7F : (i == 1) ? 8'h80 : 8'($random(seed));
            wr_reg(SCPC_OFF_TRIM, v);
            rd_chk(SCPC_OFF_TRIM, {24'h0, v});
            idle(1);
            chk_reg({16'h0, range_sel, fine, trim_out}, {16'h0, v, v});
        end
        be <= 4'hE;
        wr_reg(SCPC_OFF_TRIM, ~v);
        rd_chk(SCPC_OFF_TRIM, {24'h0, v});
        idle(1);
        be <= 4'hF;
        $display("test trim done");
        for (int r = 0; r < 2; r++) begin
            pll_sys <= 1'b0;
            v = {5'($random(seed)), r[0], 1'b1, 1'b1};
            wr_reg(SCPC_OFF_PLL, v);
            rd_chk(SCPC_OFF_PLL, {29'h0, r[0], 2'b10});
            idle(LOCK_SIM + 3);
            rd_chk(SCPC_OFF_PLL, {29'h0, r[0], 2'b11});
            chk_reg({29'h0, rate_sel, pll_run, osc_run}, {29'h0, r[0], 2'b11});
            chk_reg({31'h0, locked}, 32'h1);
            wr_reg(SCPC_OFF_PLL, {v[7:3], r[0], 2'b00});
            idle(3);
            rd_chk(SCPC_OFF_PLL, {29'h0, r[0], 2'b00});
            chk_reg({31'h0, locked}, 32'h0);
            pll_sys <= 1'b1;
            idle(1);
            chk_reg({30'h0, pll_run, osc_run}, 32'h3);
            rd_chk(SCPC_OFF_PLL, {29'h0, r[0], 2'b10});
            idle(1);
        end
        pll_sys <= 1'b0;
        $display("test pll done");
        for (int c = 0; c < 16; c++) begin
            set_div(4'(c));
        end
        set_div(4'($random(seed)));
        $display("test divider codes done");
        wr_reg(SCPC_OFF_DIV, 8'h81);
        wr_reg(SCPC_OFF_DIV, 8'h05);
        rd_chk(SCPC_OFF_DIV, {28'h0, cur});
        wr_reg(SCPC_OFF_DIV, 8'h80);
        wr_reg(SCPC_OFF_DIV, 8'h80);
        rd_chk(SCPC_OFF_DIV, {24'h0, 4'h8, cur});
        wr_reg(SCPC_OFF_DIV, 8'h02);
        rd_chk(SCPC_OFF_DIV, {28'h0, cur});
        wr_reg(SCPC_OFF_DIV, 8'h80);
        idle(4);
        wr_reg(SCPC_OFF_DIV, 8'h71);
        rd_chk(SCPC_OFF_DIV, {28'h0, cur});
        idle(1);
        $display("test unlock window done");
        reset_dut(1'b0);
        rd_chk(SCPC_OFF_TRIM, 32'h80);
        rd_chk(SCPC_OFF_DIV, 32'h0);
        idle(1);
        measure(4'h0);
        $display("test second reset done");
        end_sim();
    end
endmodule
`default_nettype wire
